// ==== verilog/emw_pkg.sv ====
package emw_pkg;
  // Command block layout and function codes.
  localparam logic [3:0]  CMD_BLOCK_MODE_OFS = 4'h2;
  localparam logic [7:0]  FC_READ_MODE       = 8'h0C;  // Function code 14 in octal.
  localparam logic [7:0]  FC_WRITE_MODE      = 8'h0D;  // Function code 15 in octal.
  // Mode word field positions.
  localparam int          RX_CHAIN_DIS_BIT   = 13;
  localparam int          TX_PAD_BIT         = 12;
  localparam int          COLL_CHECK_BIT     = 11;
  localparam int          MAINT_DIS_BIT      = 9;
  localparam int          TX_FCS_DIS_BIT     = 3;
  localparam int          LOOPBACK_BIT       = 2;
  localparam int          SELF_RX_SUP_BIT    = 0;
  localparam logic [15:0] MUST_BE_ZERO_BITS  = 16'h05F2;
  localparam logic [15:0] MODE_IMPL_MASK     = 16'h3A0D;
  localparam logic [15:0] MODE_RESET         = 16'h0000;
  // Frame geometry.
  localparam logic [15:0] TX_MIN_LEN         = 16'h0040;
  localparam logic [2:0]  FCS_BYTES          = 3'h4;
  localparam logic [31:0] CRC_INIT           = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE        = 32'hDEBB20E3;  // Register left by a good frame, low bit first.
  // Collision test window after each transmission made with collision checking on.
  localparam int          CLK_MHZ            = 20;
  localparam int          COLL_WINDOW_NS     = 2000;
  localparam int          COLL_WINDOW_CYC    = (COLL_WINDOW_NS * CLK_MHZ) / 1000;
  // Transmit FIFO shape.
  localparam int          FIFO_WIDTH         = 9;
  localparam int          FIFO_DEPTH         = 16;
  typedef enum logic [2:0] {
    EMW_TX_IDLE = 3'b000,
    EMW_TX_DATA = 3'b001,
    EMW_TX_PAD  = 3'b011,
    EMW_TX_FCS  = 3'b010,
    EMW_TX_CTST = 3'b110
  } emw_tx_e;
endpackage

// ==== verilog/emw_fifo.sv ====
`timescale 1ns/100ps
module emw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  // Full and empty come straight from the fill count, so the writer stalls honestly.
  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage written by index.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end
endmodule

// ==== verilog/emw_crc8.sv ====
`timescale 1ns/100ps
module emw_crc8 (
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc_out
);
  // Reflected frame check polynomial, one byte per call, low bit first.
  always_comb begin
    crc_out = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (crc_out[0] ^ data[i]) begin
        crc_out = (crc_out >> 1) ^ 32'hEDB88320;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end
endmodule

// ==== verilog/emw_mode_ctrl.sv ====
`timescale 1ns/100ps
module emw_mode_ctrl
  import emw_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_function_code,
  input  wire logic [15:0] cmd_mode_word,
  output logic             cmd_done,
  output logic             cmd_function_error,
  output logic             cmd_mode_we,
  output logic      [15:0] cmd_mode_rd,
  input  wire logic [7:0]  tx_in_data,
  input  wire logic        tx_in_last,
  input  wire logic        tx_in_valid,
  output logic             tx_in_ready,
  output logic      [7:0]  tx_pin_data,
  output logic             tx_pin_en,
  input  wire logic [7:0]  rx_pin_data,
  input  wire logic        rx_pin_dv,
  input  wire logic        col_test_pin,
  input  wire logic [15:0] rx_buf_len,
  output logic      [7:0]  rx_out_data,
  output logic             rx_out_valid,
  output logic             rx_out_end,
  output logic             rx_crc_error,
  output logic             rx_truncated,
  output logic             own_address_match_flag,
  output logic             coll_test_done,
  output logic             coll_test_fail,
  input  wire logic        maint_msg_rx,
  input  wire logic        sysid_due,
  output logic             maint_reply_go,
  output logic             sysid_go
);
  import emw_pkg::*;

  logic [15:0] link_mode_word;
  logic        rx_chain_disable;
  logic        tx_short_pad_enable;
  logic        collision_check_enable;
  logic        maint_reply_disable;
  logic        tx_fcs_disable;
  logic        loopback;
  logic        self_rx_suppress;
  logic        fn_ok;
  logic        mbz_bad;

  assign rx_chain_disable       = link_mode_word[RX_CHAIN_DIS_BIT];
  assign tx_short_pad_enable    = link_mode_word[TX_PAD_BIT];
  assign collision_check_enable = link_mode_word[COLL_CHECK_BIT];
  assign maint_reply_disable    = link_mode_word[MAINT_DIS_BIT];
  assign tx_fcs_disable         = link_mode_word[TX_FCS_DIS_BIT];
  assign loopback               = link_mode_word[LOOPBACK_BIT];
  assign self_rx_suppress       = link_mode_word[SELF_RX_SUP_BIT];
  assign fn_ok   = (cmd_function_code[15:8] == 8'h00);
  assign mbz_bad = |(cmd_mode_word & MUST_BE_ZERO_BITS);

  // Mode word; a rejected write leaves the old word in place.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_mode_word <= MODE_RESET;
    end else if (cmd_valid && fn_ok && cmd_function_code[7:0] == FC_WRITE_MODE && !mbz_bad) begin
      link_mode_word <= cmd_mode_word & MODE_IMPL_MASK;
    end
  end

  // Command answer, one cycle after the request.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_done           <= 1'b0;
      cmd_function_error <= 1'b0;
      cmd_mode_we        <= 1'b0;
      cmd_mode_rd        <= 16'h0000;
    end else begin
      cmd_done           <= cmd_valid;
      cmd_function_error <= 1'b0;
      cmd_mode_we        <= 1'b0;
      if (cmd_valid) begin
        if (!fn_ok) begin
          cmd_function_error <= 1'b1;
        end else if (cmd_function_code[7:0] == FC_READ_MODE) begin
          cmd_mode_we <= 1'b1;
          cmd_mode_rd <= link_mode_word;
        end else if (cmd_function_code[7:0] == FC_WRITE_MODE) begin
          cmd_function_error <= mbz_bad;
        end else begin
          cmd_function_error <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      maint_reply_go <= 1'b0;
      sysid_go       <= 1'b0;
    end else begin
      maint_reply_go <= maint_msg_rx && !maint_reply_disable;
      sysid_go       <= sysid_due && !maint_reply_disable;
    end
  end

  // Transmit side: the FIFO decouples the host stream from the wire.
  logic [8:0]  fifo_q;
  logic        fifo_valid;
  logic        fifo_pop;
  emw_tx_e     tx_state;
  logic [15:0] tx_count;
  logic [2:0]  fcs_idx;
  logic [31:0] tx_crc;
  logic [31:0] tx_crc_next;
  logic [7:0]  tx_byte;
  logic        tx_pad_f;
  logic        tx_nofcs_f;
  logic        tx_ct_f;
  logic        tx_loop_f;
  logic [7:0]  ct_count;
  logic        ct_seen;
  logic        tx_active;

  emw_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_data   ({tx_in_last, tx_in_data}),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .out_data  (fifo_q),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign fifo_pop  = (tx_state == EMW_TX_DATA);
  assign tx_active = (tx_state == EMW_TX_DATA) || (tx_state == EMW_TX_PAD) || (tx_state == EMW_TX_FCS);
  // Pad bytes are zero; frame check bytes go out low byte first, inverted.
  always_comb begin
    tx_byte = 8'h00;
    if (tx_state == EMW_TX_DATA) begin
      tx_byte = fifo_q[7:0];
    end else if (tx_state == EMW_TX_FCS) begin
      tx_byte = ~tx_crc[8*fcs_idx[1:0] +: 8];
    end
  end

  emw_crc8 u_tx_crc (
    .crc_in  (tx_crc),
    .data    (tx_byte),
    .crc_out (tx_crc_next)
  );

  // Transmit sequencer. An underrun simply waits in DATA for the next byte.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state   <= EMW_TX_IDLE;
      tx_count   <= 16'h0000;
      fcs_idx    <= 3'h0;
      tx_crc     <= CRC_INIT;
      tx_pad_f   <= 1'b0;
      tx_nofcs_f <= 1'b0;
      tx_ct_f    <= 1'b0;
      tx_loop_f  <= 1'b0;
      ct_count   <= 8'h00;
    end else begin
      case (tx_state)
        EMW_TX_IDLE: begin
          if (fifo_valid) begin
            tx_pad_f   <= tx_short_pad_enable;
            tx_nofcs_f <= tx_fcs_disable;
            tx_ct_f    <= collision_check_enable;
            tx_loop_f  <= loopback;
            tx_count   <= 16'h0000;
            tx_crc     <= CRC_INIT;
            tx_state   <= EMW_TX_DATA;
          end
        end
        EMW_TX_DATA: begin
          if (fifo_valid) begin
            tx_count <= tx_count + 16'h0001;
            tx_crc   <= tx_crc_next;
            fcs_idx  <= 3'h0;
            if (fifo_q[8]) begin
              if (tx_pad_f && (tx_count + 16'h0001) < TX_MIN_LEN) begin
                tx_state <= EMW_TX_PAD;
              end else if (tx_nofcs_f) begin
                tx_state <= EMW_TX_CTST;
              end else begin
                tx_state <= EMW_TX_FCS;
              end
            end
          end
        end
        EMW_TX_PAD: begin
          tx_count <= tx_count + 16'h0001;
          tx_crc   <= tx_crc_next;
          if ((tx_count + 16'h0001) >= TX_MIN_LEN) begin
            tx_state <= tx_nofcs_f ? EMW_TX_CTST : EMW_TX_FCS;
          end
        end
        EMW_TX_FCS: begin
          fcs_idx <= fcs_idx + 3'h1;
          if (fcs_idx == FCS_BYTES - 3'h1) begin
            tx_state <= EMW_TX_CTST;
          end
        end
        EMW_TX_CTST: begin
          ct_count <= ct_count + 8'h01;
          if (!tx_ct_f || ct_count == 8'(COLL_WINDOW_CYC - 1)) begin
            ct_count <= 8'h00;
            tx_state <= EMW_TX_IDLE;
          end
        end
        default: begin
          tx_state <= EMW_TX_IDLE;
        end
      endcase
    end
  end

  // Pin inputs pass two flip-flops before use.
  logic [9:0] pin_s1;
  logic [9:0] pin_s2;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1 <= 10'h000;
      pin_s2 <= 10'h000;
    end else begin
      pin_s1 <= {col_test_pin, rx_pin_dv, rx_pin_data};
      pin_s2 <= pin_s1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ct_seen        <= 1'b0;
      coll_test_done <= 1'b0;
      coll_test_fail <= 1'b0;
    end else begin
      coll_test_done <= 1'b0;
      coll_test_fail <= 1'b0;
      if (tx_state != EMW_TX_CTST) begin
        ct_seen <= 1'b0;
      end else if (pin_s2[9] && !tx_loop_f) begin
        ct_seen <= 1'b1;
      end
      if (tx_state == EMW_TX_CTST && tx_ct_f && ct_count == 8'(COLL_WINDOW_CYC - 1)) begin
        coll_test_done <= 1'b1;
        coll_test_fail <= tx_loop_f || !(ct_seen || pin_s2[9]);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_pin_data <= 8'h00;
      tx_pin_en   <= 1'b0;
    end else begin
      tx_pin_data <= tx_byte;
      tx_pin_en   <= tx_active && !(tx_state == EMW_TX_DATA && !fifo_valid) && !tx_loop_f;
    end
  end

  // Receive source: transmitter output in loopback, else the synchronised wire.
  logic       lb_dv;
  logic [7:0] lb_data;
  logic       rx_dv;
  logic [7:0] rx_d;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lb_dv   <= 1'b0;
      lb_data <= 8'h00;
    end else begin
      lb_dv   <= tx_active && !(tx_state == EMW_TX_DATA && !fifo_valid) && tx_loop_f;
      lb_data <= tx_byte;
    end
  end
  assign rx_dv = tx_loop_f ? lb_dv : pin_s2[8];
  assign rx_d  = tx_loop_f ? lb_data : pin_s2[7:0];

  logic        rx_in_frame;
  logic        rx_self;
  logic        rx_drop;
  logic        rx_trunc_en;
  logic [15:0] rx_limit;
  logic [15:0] rx_count;
  logic [31:0] rx_crc;
  logic [31:0] rx_crc_next;

  emw_crc8 u_rx_crc (
    .crc_in  (rx_in_frame ? rx_crc : CRC_INIT),
    .data    (rx_d),
    .crc_out (rx_crc_next)
  );

  // Receive framing, per-frame mode capture and delivery.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_in_frame            <= 1'b0;
      rx_self                <= 1'b0;
      rx_drop                <= 1'b0;
      rx_trunc_en            <= 1'b0;
      rx_limit               <= 16'h0000;
      rx_count               <= 16'h0000;
      rx_crc                 <= CRC_INIT;
      rx_out_data            <= 8'h00;
      rx_out_valid           <= 1'b0;
      rx_out_end             <= 1'b0;
      rx_crc_error           <= 1'b0;
      rx_truncated           <= 1'b0;
      own_address_match_flag <= 1'b0;
    end else begin
      rx_out_valid           <= 1'b0;
      rx_out_end             <= 1'b0;
      own_address_match_flag <= 1'b0;
      if (rx_dv) begin
        rx_crc <= rx_crc_next;
        if (!rx_in_frame) begin
          rx_in_frame  <= 1'b1;
          rx_self      <= tx_active && !tx_loop_f;
          rx_drop      <= tx_active && !tx_loop_f && self_rx_suppress;
          rx_trunc_en  <= rx_chain_disable;
          rx_limit     <= rx_buf_len;
          rx_count     <= 16'h0001;
          rx_truncated <= 1'b0;
        end else begin
          rx_count <= rx_count + 16'h0001;
        end
        if (rx_in_frame && rx_trunc_en && rx_count >= rx_limit) begin
          rx_truncated <= 1'b1;
        end else if (!(rx_in_frame ? rx_drop : (tx_active && !tx_loop_f && self_rx_suppress))) begin
          rx_out_valid <= 1'b1;
          rx_out_data  <= rx_d;
        end
      end else if (rx_in_frame) begin
        rx_in_frame <= 1'b0;
        if (rx_drop) begin
          own_address_match_flag <= 1'b1;
        end else begin
          rx_out_end   <= 1'b1;
          rx_crc_error <= rx_self || (rx_crc != CRC_RESIDUE);
        end
      end
    end
  end
endmodule

// ==== dv/emw_mode_ctrl_props.sv ====
`timescale 1ns/100ps
// Shadows the mode word from accepted writes and checks the outputs against it.
module emw_mode_ctrl_props
  import emw_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        cmd_valid,
  input wire logic [15:0] cmd_function_code,
  input wire logic [15:0] cmd_mode_word,
  input wire logic        cmd_done,
  input wire logic        cmd_function_error,
  input wire logic        cmd_mode_we,
  input wire logic [15:0] cmd_mode_rd,
  input wire logic        tx_pin_en,
  input wire logic        coll_test_done,
  input wire logic        coll_test_fail,
  input wire logic        maint_msg_rx,
  input wire logic        sysid_due,
  input wire logic        maint_reply_go,
  input wire logic        sysid_go
);
  logic [15:0] mode_sh;
  logic        wr_cmd;
  logic        mbz_hit;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // A refused write must leave the shadow alone, just as it leaves the real word.
  assign wr_cmd  = cmd_valid && cmd_function_code == {8'h00, FC_WRITE_MODE};
  assign mbz_hit = (cmd_mode_word & MUST_BE_ZERO_BITS) != 16'h0000;
  // Shadow copy of the stored mode word.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_sh <= MODE_RESET;
    end else if (wr_cmd && !mbz_hit) begin
      mode_sh <= cmd_mode_word & MODE_IMPL_MASK;
    end
  end
  sequence s_read; cmd_valid && cmd_function_code == {8'h00, FC_READ_MODE}; endsequence
  sequence s_bad_write; wr_cmd && mbz_hit; endsequence
  property p_done; cmd_valid |=> cmd_done; endproperty
  a_done: assert property (p_done) else $error("no done after command");
  property p_no_done; !cmd_valid |=> !cmd_done; endproperty
  a_no_done: assert property (p_no_done) else $error("done without command");
  property p_read;
    s_read |=> !cmd_function_error && cmd_mode_we && cmd_mode_rd == $past(mode_sh);
  endproperty
  a_read: assert property (p_read) else $error("read mode returned a wrong word");
  property p_bad_write; s_bad_write |=> cmd_function_error && !cmd_mode_we; endproperty
  a_bad_write: assert property (p_bad_write) else $error("reserved bits accepted");
  property p_upper; cmd_valid && cmd_function_code[15:8] != 8'h00 |=> cmd_function_error; endproperty
  a_upper: assert property (p_upper) else $error("nonzero code upper byte accepted");
  property p_maint; maint_msg_rx |=> maint_reply_go == !$past(mode_sh[MAINT_DIS_BIT]); endproperty
  a_maint: assert property (p_maint) else $error("maintenance reply wrong");
  property p_sysid; sysid_due |=> sysid_go == !$past(mode_sh[MAINT_DIS_BIT]); endproperty
  a_sysid: assert property (p_sysid) else $error("identification message wrong");
  property p_loop; mode_sh[LOOPBACK_BIT] |-> !tx_pin_en; endproperty
  a_loop: assert property (p_loop) else $error("transceiver driven in loopback");
  property p_loop_coll;
    coll_test_done && mode_sh[LOOPBACK_BIT] && mode_sh[COLL_CHECK_BIT] |-> coll_test_fail;
  endproperty
  a_loop_coll: assert property (p_loop_coll) else $error("collision test passed in loopback");
  property p_fail_done; coll_test_fail |-> coll_test_done; endproperty
  a_fail_done: assert property (p_fail_done) else $error("collision fail without done");
endmodule

bind emw_mode_ctrl emw_mode_ctrl_props u_emw_mode_ctrl_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_function_code(cmd_function_code),
  .cmd_mode_word(cmd_mode_word), .cmd_done(cmd_done), .cmd_function_error(cmd_function_error),
  .cmd_mode_we(cmd_mode_we), .cmd_mode_rd(cmd_mode_rd), .tx_pin_en(tx_pin_en),
  .coll_test_done(coll_test_done), .coll_test_fail(coll_test_fail), .maint_msg_rx(maint_msg_rx),
  .sysid_due(sysid_due), .maint_reply_go(maint_reply_go), .sysid_go(sysid_go)
);

// ==== dv/tb.sv ====
`timescale 1ns/100ps
module tb;
  import emw_pkg::*;
  typedef struct {logic [15:0] mode; int n, n2, rx_n, tx, rx; logic col, match, trunc, crc; logic [1:0] coll;} emw_case_s;
  logic        ref_clk, sys_rst, cmd_valid, tx_in_last, tx_in_valid, rx_pin_dv, col_test_pin, maint_msg_rx, sysid_due;
  logic [15:0] cmd_function_code, cmd_mode_word, rx_buf_len, cmd_mode_rd;
  logic [7:0]  tx_in_data, rx_pin_data, tx_pin_data, rx_out_data;
  logic        cmd_done, cmd_function_error, cmd_mode_we, tx_in_ready, tx_pin_en, rx_out_valid, rx_out_end;
  logic        rx_crc_error, rx_truncated, own_address_match_flag, coll_test_done, coll_test_fail;
  logic        maint_reply_go, sysid_go, clr, pad_on, tx_bad, match_seen, lb_on, rx_bad;
  logic [1:0]  coll_res, rx_flags;
  int          tx_cnt, rx_cnt, frm_len, refused, error_cnt, total_checks;
  int          legal[7] = '{13, 12, 11, 9, 3, 2, 0};
  int          must_be_zero_bits[7]   = '{10, 8, 7, 6, 5, 4, 1};
  emw_case_s   cases[11] = '{
    '{16'h1000, 10, 0, 0, 68, 0, 0, 0, 0, 0, 2'b00}, '{16'h1008, 10, 0, 0, 64, 0, 0, 0, 0, 0, 2'b00},
    '{16'h0008, 10, 0, 0, 10, 0, 0, 0, 0, 0, 2'b00}, '{16'h1000, 4, 20, 0, 136, 0, 0, 0, 0, 0, 2'b00},
    '{16'h0800, 8, 0, 0, 12, 0, 0, 0, 0, 0, 2'b11}, '{16'h0800, 8, 0, 0, 12, 0, 1, 0, 0, 0, 2'b10},
    '{16'h0804, 8, 0, 0, 0, 12, 0, 0, 0, 0, 2'b11}, '{16'h0000, 16, 0, 6, 20, 6, 0, 0, 0, 1, 2'b00},
    '{16'h0001, 16, 0, 6, 20, 0, 0, 1, 0, 0, 2'b00}, '{16'h2000, 0, 0, 8, 0, 4, 0, 0, 1, 1, 2'b00},
    '{16'h0000, 0, 0, 8, 0, 8, 0, 0, 0, 1, 2'b00}};

  emw_mode_ctrl u_emw_mode_ctrl (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_function_code(cmd_function_code),
    .cmd_mode_word(cmd_mode_word), .cmd_done(cmd_done), .cmd_function_error(cmd_function_error),
    .cmd_mode_we(cmd_mode_we), .cmd_mode_rd(cmd_mode_rd), .tx_in_data(tx_in_data), .tx_in_last(tx_in_last),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_pin_data(tx_pin_data), .tx_pin_en(tx_pin_en),
    .rx_pin_data(rx_pin_data), .rx_pin_dv(rx_pin_dv), .col_test_pin(col_test_pin), .rx_buf_len(rx_buf_len),
    .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid), .rx_out_end(rx_out_end),
    .rx_crc_error(rx_crc_error), .rx_truncated(rx_truncated), .own_address_match_flag(own_address_match_flag),
    .coll_test_done(coll_test_done), .coll_test_fail(coll_test_fail), .maint_msg_rx(maint_msg_rx),
    .sysid_due(sysid_due), .maint_reply_go(maint_reply_go), .sysid_go(sysid_go)
  );

  // Clock at 20 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Tallies what leaves the block; the pad check only runs when padding is on.
  always @(posedge ref_clk) begin
    if (clr) begin
      tx_cnt     <= 0;
      rx_cnt     <= 0;
      tx_bad     <= 1'b0;
      match_seen <= 1'b0;
      rx_bad     <= 1'b0;
      coll_res   <= 2'b00;
      rx_flags   <= 2'b00;
    end else begin
      if (tx_pin_en === 1'b1) begin
        tx_cnt <= tx_cnt + 1;
        if (tx_cnt < frm_len && tx_pin_data !== 8'(tx_cnt + 1)) tx_bad <= 1'b1;
        if (pad_on && tx_cnt >= frm_len && tx_cnt < TX_MIN_LEN && tx_pin_data !== 8'h00) tx_bad <= 1'b1;
      end
      if (rx_out_valid === 1'b1) begin
        rx_cnt <= rx_cnt + 1;
        // Loopback returns the sent bytes; the wire returns the bench pattern.
        if (lb_on ? (rx_cnt < frm_len && rx_out_data !== 8'(rx_cnt + 1)) : rx_out_data !== 8'(rx_cnt + 8'hA0)) begin
          rx_bad <= 1'b1;
        end
      end
      if (rx_out_end === 1'b1) rx_flags <= {rx_crc_error, rx_truncated};
      if (own_address_match_flag === 1'b1) match_seen <= 1'b1;
      if (coll_test_done === 1'b1) coll_res <= {1'b1, coll_test_fail};
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One command block; the answer stands only in the cycle after the taking edge.
  task automatic cmd(input logic [15:0] code, input logic [15:0] word, input logic err);
    cmd_valid         <= 1'b1;
    cmd_function_code <= code;
    cmd_mode_word     <= word;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    chk("cmd_done", 16'h0001, 16'(cmd_done));
    chk("cmd_function_error", 16'(err), 16'(cmd_function_error));
    chk("cmd_mode_we", 16'(code === {8'h00, FC_READ_MODE} && !err), 16'(cmd_mode_we));
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [15:0] word, input logic err);
    cmd({8'h00, FC_WRITE_MODE}, word, err);
  endtask

  task automatic rd(input logic [15:0] exp);
    cmd({8'h00, FC_READ_MODE}, 16'h0000, 1'b0);
    chk("cmd_mode_rd", exp, cmd_mode_rd);
  endtask

  // Holds each byte until an edge at which the buffer was ready; counts refusals.
  task automatic send(input int n);
    logic rdy;
    for (int i = 0; i < n; i++) begin
      tx_in_valid <= 1'b1;
      tx_in_data  <= 8'(i + 1);
      tx_in_last  <= (i == n - 1);
      do begin
        @(negedge ref_clk);
        rdy = tx_in_ready;
        @(posedge ref_clk);
        if (rdy !== 1'b1) refused++;
      end while (rdy !== 1'b1);
    end
  endtask

  // Runs one frame case, then waits until the wire has been quiet long enough.
  task automatic run(input emw_case_s c);
    int q;
    wr(c.mode, 1'b0);
    clr     <= 1'b1;
    frm_len <= c.n;
    pad_on  <= c.mode[TX_PAD_BIT];
    lb_on   <= c.mode[LOOPBACK_BIT];
    refused = 0;
    @(posedge ref_clk);
    clr <= 1'b0;
    fork
      begin
        send(c.n);
        send(c.n2);
        tx_in_valid <= 1'b0;
      end
      if (c.rx_n > 0) begin
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < c.rx_n; i++) begin
          rx_pin_dv   <= 1'b1;
          rx_pin_data <= 8'hA0 + 8'(i);
          @(posedge ref_clk);
        end
        rx_pin_dv   <= 1'b0;
        rx_pin_data <= ~rx_pin_data;
      end
      if (c.col) begin
        repeat (20) @(posedge ref_clk);
        col_test_pin <= 1'b1;
        repeat (10) @(posedge ref_clk);
        col_test_pin <= 1'b0;
      end
    join
    q = 0;
    for (int i = 0; i < 800 && q < 80; i++) begin
      @(posedge ref_clk);
      q = (tx_pin_en === 1'b1) ? 0 : q + 1;
    end
  endtask

  // Watchdog well beyond the roughly 1,500 cycles the run is expected to take.
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    results();
  end

  initial begin
    {cmd_valid, tx_in_last, tx_in_valid, rx_pin_dv, col_test_pin, maint_msg_rx, sysid_due, clr} = 8'h00;
    {cmd_function_code, cmd_mode_word, tx_in_data, rx_pin_data} = 48'h0;
    {error_cnt, total_checks, frm_len, refused} = '0;
    pad_on     = 1'b0;
    lb_on      = 1'b0;
    rx_buf_len = 16'h0004;
    sys_rst    = 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(MODE_RESET);
    foreach (legal[i]) begin
      wr(16'h0001 << legal[i], 1'b0);
      rd(16'h0001 << legal[i]);
    end
    wr(MODE_IMPL_MASK, 1'b0);
    foreach (must_be_zero_bits[i]) begin
      wr(MODE_IMPL_MASK | (16'h0001 << must_be_zero_bits[i]), 1'b1);
      rd(MODE_IMPL_MASK);
    end
    cmd({8'h00, FC_READ_MODE}, 16'hFFFF, 1'b0);
    chk("cmd_mode_rd", MODE_IMPL_MASK, cmd_mode_rd);
    cmd(16'h010D, 16'h0000, 1'b1);
    cmd(16'h010C, 16'h0000, 1'b1);
    cmd(16'h0010, 16'h0000, 1'b1);
    rd(MODE_IMPL_MASK);
    wr(16'hC000, 1'b0);
    rd(16'h0000);
    for (int m = 0; m < 2; m++) begin
      wr(16'(m) << MAINT_DIS_BIT, 1'b0);
      maint_msg_rx <= 1'b1;
      sysid_due    <= 1'b1;
      @(posedge ref_clk);
      maint_msg_rx <= 1'b0;
      sysid_due    <= 1'b0;
      #1;
      chk("maint_reply_go", 16'(m == 0), 16'(maint_reply_go));
      chk("sysid_go", 16'(m == 0), 16'(sysid_go));
      @(posedge ref_clk);
    end
    foreach (cases[i]) begin
      run(cases[i]);
      chk("tx_bytes", 16'(cases[i].tx), 16'(tx_cnt));
      chk("tx_content", 16'h0000, 16'(tx_bad));
      chk("rx_bytes", 16'(cases[i].rx), 16'(rx_cnt));
      chk("rx_content", 16'h0000, 16'(rx_bad));
      chk("coll_result", 16'(cases[i].coll), 16'(coll_res));
      chk("own_match", 16'(cases[i].match), 16'(match_seen));
      if (cases[i].rx > 0) chk("rx_status", 16'({cases[i].crc, cases[i].trunc}), 16'(rx_flags));
      if (cases[i].n2 > 0) chk("fifo_refused", 16'h0001, 16'(refused > 0));
    end
    results();
  end
endmodule
